// File: hw/sq_map.svh
`ifndef SQ_MAP_SVH
`define SQ_MAP_SVH

// ----------------------------------------
// apb register byte addresses
// ----------------------------------------
`define SQ_ADDR_W 8
`define SQ_OFF_CMD 8'h00
`define SQ_OFF_DATA_LOW 8'h04
`define SQ_OFF_RESPONSE 8'h08
`define SQ_OFF_CAP 8'h0c
`define SQ_OFF_STB 8'h10
`define SQ_OFF_IDENT 8'h14
`define SQ_OFF_VIOL 8'h18

// ----------------------------------------
// command words
// ----------------------------------------
`define SQ_CMD_READ_INTERRUPTERS 16'hcaff
`define SQ_CMD_IDENT_READBACK 16'hccff
`define SQ_CMD_READ_PROTOCOL 16'hdfff
`define SQ_CMD_READ_PROTO_ERR 16'hcdff
`define SQ_CMD_READ_STATUS_BYTE_CMD 16'hcfff

// ----------------------------------------
// protocol error codes
// ----------------------------------------
`define SQ_ERR_NONE 16'hffff
`define SQ_ERR_MULTI_QUERY 16'hfffd
`define SQ_ERR_UNSUPPORTED 16'hfffc
`define SQ_ERR_DIR_VIOL 16'hfffb
`define SQ_ERR_DOR_VIOL 16'hfffa
`define SQ_ERR_RR_VIOL 16'hfff9
`define SQ_ERR_WR_VIOL 16'hfff8

// ----------------------------------------
// reply fields and reset values
// ----------------------------------------
`define SQ_INT_CNT_W 3
`define SQ_IDENT_W 13
`define SQ_IDENT_OE_BIT 13
`define SQ_CAP_RESET 16'h0000
`define SQ_STB_RESET 8'h00
`define SQ_INT_CNT_RESET 3'h1

`endif

// File: hw/sq_pkg.sv
package sq_pkg;

  // handshake flags as seen by the commander
  typedef struct packed {
    logic data_out_ready;
    logic data_in_ready;
    logic err_n;
    logic read_ready;
    logic write_ready;
  } resp_flags_t;

  // capability configuration written by local software
  typedef struct packed {
    logic [3:0] dev_dep;
    logic [2:0] int_cnt;
    logic response_gen_cap_n;
    logic event_gen_cap_n;
    logic interrupter_cmds_cap_n;
    logic handler_cmds_cap_n;
    logic trigger_cmd_cap_n;
    logic instr_ieee_proto_cap_n;
    logic instr_proto_cap_n;
    logic ext_wide_serial_cap_n;
    logic wide_serial_cap_n;
  } cap_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_ERR_RELEASE
  } exec_state_t;

endpackage : sq_pkg

// File: hw/servant_query_command_responder.sv
`timescale 1ns/100ps
`include "sq_map.svh"

// Functional notes
// (R1) interrupter count reply: count in low field, all bits above are one
// (R2) recognise ident line readback command word 16'hccff
// (R3) readback reply holds all thirteen ident lines, top two bits one
// (R4) readback reply carries output-enable flag, one while driving ident lines
// (R5) accept protocol query 16'hdfff and answer with capability word
// (R6) reserved capability bit always one, device dependent bits configurable
// (R7) response and event generation flags low when capable
// (R8) interrupter and handler command flags low when supported
// (R9) trigger, instrument and ieee instrument flags low when supported
// (R10) wide and extended wide serial flags low exactly when supported
// (R11) every reply word goes into the data-low register
// (R12) protocol error query returns current error state as one word
// (R13) error flag released before write ready rises for that query
// (R14) after error reply the stored error returns to no-error
// (R15) query overwriting unread reply records multiple-queries error
// (R16) unimplemented command records unsupported-command error
// (R17) distinct errors for data-in-ready and data-out-ready violations
// (R18) distinct errors for read-ready and write-ready violations
// (R19) only the defined error codes are ever reported
// (R20) support the status byte read command
// (R21) status byte reply placed in data-low register
// (R22) error code and low error flag held until the error query
module servant_query_command_responder
  import sq_pkg::*;
#(
  parameter int INT_CNT_W = `SQ_INT_CNT_W,
  parameter int IDENT_W = `SQ_IDENT_W
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SQ_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // ident lines
  input wire logic [IDENT_W-1:0] module_ident_lines_i,
  output logic [IDENT_W-1:0] module_ident_lines_o,
  output logic module_ident_lines_oe,
  // handshake flags
  output logic write_ready,
  output logic read_ready,
  output logic err_n
);

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic setup_phase;
  logic access_done;
  logic wr_access;
  logic rd_access;

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_access = access_done & pwrite;
  assign rd_access = access_done & ~pwrite;

  function automatic logic addr_mapped(input logic [`SQ_ADDR_W-1:0] a);
    case (a)
      `SQ_OFF_CMD, `SQ_OFF_DATA_LOW, `SQ_OFF_RESPONSE, `SQ_OFF_CAP,
      `SQ_OFF_STB, `SQ_OFF_IDENT, `SQ_OFF_VIOL: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction : addr_mapped

  function automatic logic hit(input logic [`SQ_ADDR_W-1:0] a,
                               input logic [`SQ_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  // ----------------------------------------
  // state
  // ----------------------------------------
  exec_state_t state_q;
  logic [15:0] cmd_q;
  logic [15:0] data_low_q;
  logic [15:0] err_code_q;
  resp_flags_t flags_q;
  cap_cfg_t cap_q;
  logic [7:0] stb_q;
  logic [IDENT_W-1:0] ident_drive_q;
  logic ident_oe_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // error events raised this cycle
  logic cmd_wr;
  logic dl_rd;
  logic err_wr_viol;
  logic err_rr_viol;
  logic err_dir_viol;
  logic err_dor_viol;
  logic err_unsup;
  logic err_multi;
  logic err_event;
  logic [15:0] err_event_code;
  logic is_supported;
  logic err_query_done;

  assign cmd_wr = wr_access & hit(paddr, `SQ_OFF_CMD);
  assign dl_rd = rd_access & hit(paddr, `SQ_OFF_DATA_LOW);

  // a command written while not write ready breaks that handshake
  assign err_wr_viol = cmd_wr & ~flags_q.write_ready; // R18
  // reading the reply before it is ready breaks read ready
  assign err_rr_viol = dl_rd & ~flags_q.read_ready; // R18
  assign err_dir_viol = wr_access & hit(paddr, `SQ_OFF_VIOL) & pwdata[0]; // R17
  assign err_dor_viol = wr_access & hit(paddr, `SQ_OFF_VIOL) & pwdata[1]; // R17

  always_comb
  begin
    case (cmd_q)
      `SQ_CMD_READ_INTERRUPTERS, `SQ_CMD_IDENT_READBACK, `SQ_CMD_READ_PROTOCOL,
      `SQ_CMD_READ_PROTO_ERR, `SQ_CMD_READ_STATUS_BYTE_CMD: is_supported = 1'b1;
      default: is_supported = 1'b0;
    endcase
  end

  // every supported command is a query that produces a reply
  assign err_unsup = (state_q == ST_EXEC) & ~is_supported; // R16
  assign err_multi = (state_q == ST_EXEC) & is_supported & flags_q.read_ready; // R15
  assign err_query_done = (state_q == ST_EXEC) && !flags_q.read_ready &&
                          (cmd_q == `SQ_CMD_READ_PROTO_ERR);

  assign err_event = err_wr_viol | err_rr_viol | err_dir_viol | err_dor_viol
                   | err_unsup | err_multi;

  // fixed priority; only defined codes can ever be produced
  always_comb
  begin
    if (err_multi)
      err_event_code = `SQ_ERR_MULTI_QUERY; // R15
    else if (err_unsup)
      err_event_code = `SQ_ERR_UNSUPPORTED; // R16
    else if (err_dir_viol)
      err_event_code = `SQ_ERR_DIR_VIOL; // R17
    else if (err_dor_viol)
      err_event_code = `SQ_ERR_DOR_VIOL; // R17
    else if (err_rr_viol)
      err_event_code = `SQ_ERR_RR_VIOL; // R18
    else
      err_event_code = `SQ_ERR_WR_VIOL; // R18 R19
  end

  // ----------------------------------------
  // reply words
  // ----------------------------------------
  logic [15:0] proto_word;
  logic [15:0] reply_word;

  assign proto_word = {1'b1, cap_q.dev_dep, 1'b1, // R6
                       cap_q.response_gen_cap_n, cap_q.event_gen_cap_n, // R7
                       1'b0,
                       cap_q.interrupter_cmds_cap_n, cap_q.handler_cmds_cap_n, // R8
                       cap_q.trigger_cmd_cap_n, cap_q.instr_ieee_proto_cap_n,
                       cap_q.instr_proto_cap_n, // R9
                       cap_q.ext_wide_serial_cap_n, cap_q.wide_serial_cap_n}; // R10

  always_comb
  begin
    case (cmd_q)
      `SQ_CMD_READ_INTERRUPTERS:
        reply_word = {{(16-INT_CNT_W){1'b1}}, cap_q.int_cnt[INT_CNT_W-1:0]}; // R1
      `SQ_CMD_IDENT_READBACK:
        reply_word = {2'b11, ident_oe_q, module_ident_lines_i}; // R2 R3 R4
      `SQ_CMD_READ_PROTOCOL:
        reply_word = proto_word; // R5
      `SQ_CMD_READ_PROTO_ERR:
        reply_word = err_code_q; // R12
      `SQ_CMD_READ_STATUS_BYTE_CMD:
        reply_word = {8'hff, stb_q}; // R20 R21
      default:
        reply_word = 16'hffff;
    endcase
  end

  // ----------------------------------------
  // command execution
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_IDLE;
      cmd_q <= 16'h0000;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (cmd_wr && flags_q.write_ready)
          begin
            cmd_q <= pwdata[15:0];
            state_q <= ST_EXEC;
          end
        ST_EXEC:
          if (err_query_done)
            state_q <= ST_ERR_RELEASE; // R13
          else
            state_q <= ST_IDLE;
        ST_ERR_RELEASE:
          state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // reply register; an unread reply is never overwritten
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      data_low_q <= 16'hffff;
    else if (state_q == ST_EXEC && is_supported && !flags_q.read_ready)
      data_low_q <= reply_word; // R11
  end

  // ----------------------------------------
  // handshake flags
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      flags_q.write_ready <= 1'b1;
    else if (cmd_wr && flags_q.write_ready)
      flags_q.write_ready <= 1'b0;
    else if (state_q == ST_EXEC && !err_query_done)
      flags_q.write_ready <= 1'b1;
    else if (state_q == ST_ERR_RELEASE)
      flags_q.write_ready <= 1'b1; // R13
  end

  // reply set wins over a read in the same cycle
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      flags_q.read_ready <= 1'b0;
    else if (state_q == ST_EXEC && is_supported && !flags_q.read_ready)
      flags_q.read_ready <= 1'b1;
    else if (dl_rd)
      flags_q.read_ready <= 1'b0;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      {flags_q.data_in_ready, flags_q.data_out_ready} <= 2'b10;
    else
      {flags_q.data_in_ready, flags_q.data_out_ready} <= 2'b10;
  end

  // ----------------------------------------
  // error state
  // ----------------------------------------
  // first error is kept; a new event in the clearing cycle wins
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      err_code_q <= `SQ_ERR_NONE;
      flags_q.err_n <= 1'b1;
    end
    else if (err_event && (flags_q.err_n || err_query_done))
    begin
      err_code_q <= err_event_code; // R22
      flags_q.err_n <= 1'b0; // R22
    end
    else if (err_query_done)
    begin
      err_code_q <= `SQ_ERR_NONE; // R14
      flags_q.err_n <= 1'b1; // R13
    end
  end

  // ----------------------------------------
  // local configuration registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cap_q <= `SQ_CAP_RESET;
      cap_q.int_cnt <= `SQ_INT_CNT_RESET;
    end
    else if (wr_access && hit(paddr, `SQ_OFF_CAP))
      cap_q <= pwdata[15:0];
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      stb_q <= `SQ_STB_RESET;
    else if (wr_access && hit(paddr, `SQ_OFF_STB))
      stb_q <= pwdata[7:0];
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ident_drive_q <= '0;
      ident_oe_q <= 1'b0;
    end
    else if (wr_access && hit(paddr, `SQ_OFF_IDENT))
    begin
      ident_drive_q <= pwdata[IDENT_W-1:0];
      ident_oe_q <= pwdata[`SQ_IDENT_OE_BIT]; // R4
    end
  end

  // ----------------------------------------
  // apb response
  // ----------------------------------------
  // zero wait states: ready is registered from the setup cycle and is high in the first access cycle
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      {pready_q, pslverr_q} <= 2'b00;
    else
      {pready_q, pslverr_q} <= {setup_phase, setup_phase & ~addr_mapped(paddr)};
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      prdata_q <= 32'h0000_0000;
    else if (setup_phase && !pwrite)
    begin
      case (paddr)
        `SQ_OFF_CMD: prdata_q <= {16'h0000, cmd_q};
        `SQ_OFF_DATA_LOW: prdata_q <= {16'h0000, data_low_q};
        `SQ_OFF_RESPONSE: prdata_q <= {27'h0, flags_q};
        `SQ_OFF_CAP: prdata_q <= {16'h0000, cap_q};
        `SQ_OFF_STB: prdata_q <= {24'h0, stb_q};
        `SQ_OFF_IDENT: prdata_q <= {18'h0, ident_oe_q, ident_drive_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign module_ident_lines_o = ident_drive_q;
  assign module_ident_lines_oe = ident_oe_q;
  assign write_ready = flags_q.write_ready;
  assign read_ready = flags_q.read_ready;
  assign err_n = flags_q.err_n;

endmodule : servant_query_command_responder

// File: tb/sq_properties.sv
`timescale 1ns/100ps
`include "sq_map.svh"

module sq_properties
#(
  parameter int INT_CNT_W = `SQ_INT_CNT_W,
  parameter int IDENT_W = `SQ_IDENT_W
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SQ_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // ident lines and flags
  input wire logic [IDENT_W-1:0] module_ident_lines_o,
  input wire logic module_ident_lines_oe,
  input wire logic write_ready,
  input wire logic read_ready,
  input wire logic err_n
);
  // ----------------------------------------
  // decoded accesses
  // ----------------------------------------
  logic acc;
  logic cmd;
  logic qerr;
  assign acc = psel && penable && pready;
  assign cmd = acc && pwrite && paddr == `SQ_OFF_CMD;
  // no unread reply, so the query cannot turn into a multi-query error
  assign qerr = cmd && write_ready && !read_ready && pwdata[15:0] == `SQ_CMD_READ_PROTO_ERR;

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_unmapped_err: assert property (acc && paddr > `SQ_OFF_VIOL
    |-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
  a_cmd_busy: assert property (cmd && write_ready |=> !write_ready)
    else $error("write ready held over accepted command");
  a_reply_posted: assert property (
    cmd && write_ready && !read_ready && pwdata[15:0] == `SQ_CMD_READ_PROTOCOL
    |=> ##1 read_ready && write_ready) else $error("reply not posted");
  a_err_release: assert property (
    qerr |=> !write_ready ##1 (err_n && !write_ready) ##1 write_ready)
    else $error("error flag not released before write ready");
  a_wr_violation: assert property (cmd && !write_ready && err_n |-> ##[1:2] !err_n)
    else $error("write ready violation not recorded");
  a_err_held: assert property (!err_n && !qerr && !$past(qerr) |=> !err_n)
    else $error("error flag dropped without error query");
  a_read_clears: assert property (acc && !pwrite && paddr == `SQ_OFF_DATA_LOW |=> !read_ready)
    else $error("read ready not cleared by data read");
  a_ident_drive: assert property (
    acc && pwrite && paddr == `SQ_OFF_IDENT |=> module_ident_lines_oe == $past(pwdata[13]))
    else $error("ident output enable not updated");
  a_ident_value: assert property (acc && pwrite && paddr == `SQ_OFF_IDENT
    |=> module_ident_lines_o == $past(pwdata[IDENT_W-1:0]))
    else $error("ident drive value not updated");
endmodule : sq_properties

bind servant_query_command_responder sq_properties #(
  .INT_CNT_W(INT_CNT_W),
  .IDENT_W(IDENT_W)
) sq_properties_i (
  .mclk(mclk),
  .resetn(resetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .module_ident_lines_o(module_ident_lines_o),
  .module_ident_lines_oe(module_ident_lines_oe),
  .write_ready(write_ready),
  .read_ready(read_ready),
  .err_n(err_n)
);

// File: tb/ident_line_model.sv
`timescale 1ns/100ps

module ident_line_model (
  // local drive
  input wire logic [12:0] drv,
  input wire logic oe,
  // other modules drive the lines while we are released
  input wire logic [12:0] remote,
  // resolved lines
  output logic [12:0] lines
);
  assign lines = oe ? drv : remote;
endmodule : ident_line_model

// File: tb/servant_query_command_responder_test.sv
`timescale 1ns/100ps
`include "sq_map.svh"

module servant_query_command_responder_test;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [12:0] remote = 13'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, perr, oe, write_ready, read_ready, err_n;
  logic [12:0] lines_i, lines_o;
  logic [15:0] cap, v;
  int err_total = 0;
  int checks = 0;
  int seed = 32'h400f;

  always #4 mclk = ~mclk;

  servant_query_command_responder servant_query_command_responder_i (
    .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .module_ident_lines_i(lines_i), .module_ident_lines_o(lines_o),
    .module_ident_lines_oe(oe), .write_ready(write_ready), .read_ready(read_ready),
    .err_n(err_n));

  ident_line_model ident_line_model_i (.drv(lines_o), .oe(oe), .remote(remote),
    .lines(lines_i));

  // ----------------------------------------
  // bus tasks and expectations
  // ----------------------------------------
  task end_sim;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // rel low keeps psel up for a back-to-back transfer
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input bit rel);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    if (rel)
    begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    apb(1'b1, a, {16'h0, d}, 1'b1);
  endtask : wr

  task rdreg(input logic [7:0] a);
    @(posedge mclk);
    apb(1'b0, a, 32'h0, 1'b1);
  endtask : rdreg

  task cmd(input logic [15:0] c);
    do @(posedge mclk); while (write_ready !== 1'b1);
    apb(1'b1, `SQ_OFF_CMD, {16'h0, c}, 1'b1);
  endtask : cmd

  task query(input logic [15:0] c, input logic [15:0] exp);
    cmd(c);
    rdreg(`SQ_OFF_DATA_LOW);
    chk(rd, {16'h0, exp});
  endtask : query

  function automatic logic [15:0] pw(input logic [15:0] c);
    return {1'b1, c[15:12], 1'b1, c[8:7], 1'b0, c[6:0]};
  endfunction : pw

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    rdreg(`SQ_OFF_CAP);
    chk(rd, 32'h200);
    chk({write_ready, read_ready, err_n}, 3'b101);
    rdreg(8'h1c);
    chk({31'h0, perr}, 32'h1);
    chk(rd, 32'h0);
    wr(8'h20, 16'h1234);
    chk({31'h0, perr}, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      cap = 16'($random(seed));
      v = 16'($random(seed));
      v[13] = i[0];
      remote <= 13'($random(seed));
      wr(`SQ_OFF_CAP, cap);
      query(`SQ_CMD_READ_PROTOCOL, pw(cap));
      query(`SQ_CMD_READ_INTERRUPTERS, {13'h1fff, cap[11:9]});
      wr(`SQ_OFF_STB, v);
      query(`SQ_CMD_READ_STATUS_BYTE_CMD, {8'hff, v[7:0]});
      wr(`SQ_OFF_IDENT, v);
      query(`SQ_CMD_IDENT_READBACK, {2'b11, v[13], v[13] ? v[12:0] : remote});
    end
    cmd(`SQ_CMD_READ_PROTOCOL);
    query(`SQ_CMD_READ_PROTOCOL, pw(cap));
    chk(err_n, 1'b0);
    query(`SQ_CMD_READ_PROTO_ERR, `SQ_ERR_MULTI_QUERY);
    query(`SQ_CMD_READ_PROTO_ERR, `SQ_ERR_NONE);
    cmd(16'h7777);
    query(`SQ_CMD_READ_PROTO_ERR, `SQ_ERR_UNSUPPORTED);
    wr(`SQ_OFF_VIOL, 16'h1);
    wr(`SQ_OFF_VIOL, 16'h2);
    query(`SQ_CMD_READ_PROTO_ERR, `SQ_ERR_DIR_VIOL);
    wr(`SQ_OFF_VIOL, 16'h2);
    query(`SQ_CMD_READ_PROTO_ERR, `SQ_ERR_DOR_VIOL);
    rdreg(`SQ_OFF_DATA_LOW);
    query(`SQ_CMD_READ_PROTO_ERR, `SQ_ERR_RR_VIOL);
    do @(posedge mclk); while (write_ready !== 1'b1);
    // second word lands while the error query still holds write ready low
    apb(1'b1, `SQ_OFF_CMD, {16'h0, `SQ_CMD_READ_PROTO_ERR}, 1'b0);
    apb(1'b1, `SQ_OFF_CMD, {16'h0, `SQ_CMD_READ_PROTOCOL}, 1'b1);
    rdreg(`SQ_OFF_DATA_LOW);
    chk(rd, {16'h0, `SQ_ERR_NONE});
    query(`SQ_CMD_READ_PROTO_ERR, `SQ_ERR_WR_VIOL);
    // reset in mid-run must bring configuration and flags back to idle
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rdreg(`SQ_OFF_CAP);
    chk(rd, 32'h200);
    rdreg(`SQ_OFF_IDENT);
    chk(rd, 32'h0);
    rdreg(`SQ_OFF_RESPONSE);
    chk(rd, 32'h0d);
    chk({write_ready, read_ready, err_n}, 3'b101);
    end_sim;
  end

  initial
  begin
    #200000;
    err_total++;
    end_sim;
  end
endmodule : servant_query_command_responder_test
